// ---- pba_pkg.sv ----
// Purpose: Shared constants for the personality bit array access block
// Assumes: 8-bit register port, one 100 MHz clock
// Notes:   Offsets, field positions and reset values live here only
package pba_pkg;

  // Register port widths
  localparam int unsigned PBA_ADDR_W = 8;
  localparam int unsigned PBA_DATA_W = 8;

  // Register offsets on the plain register port
  localparam logic [7:0] PBA_SEL_OFS = 8'h0e;  // cell_select_reg
  localparam logic [7:0] PBA_SCR_OFS = 8'h0f;  // cell_status_control_reg

  // Array shape: 8 rows by 8 columns
  localparam int unsigned PBA_CELLS = 64;
  localparam int unsigned PBA_IDX_W = 6;
  localparam int unsigned PBA_ROW_W = 3;

  // Select register fields
  localparam int unsigned PBA_ROW_LSB   = 0;
  localparam int unsigned PBA_COL_LSB   = 3;
  localparam int unsigned PBA_IDX_LSB   = 0;
  localparam int unsigned PBA_SPARE_LO  = 6;
  localparam int unsigned PBA_SPARE_HI  = 7;

  // Status and control register fields
  localparam int unsigned PBA_SCR_DATA_BIT = 7;
  localparam int unsigned PBA_SCR_PGM_BIT  = 5;
  localparam int unsigned PBA_SCR_RZF_BIT  = 0;

  // Reset and idle values
  localparam logic [7:0] PBA_SEL_RESET = 8'h00;
  localparam logic       PBA_PGM_RESET = 1'b0;
  localparam logic       PBA_RZF_RESET = 1'b1;
  localparam logic [2:0] PBA_ROW_ZERO  = 3'h0;
  localparam logic [7:0] PBA_RD_IDLE   = 8'h00;
  localparam logic       PBA_CELL_ERASED = 1'b0;
  localparam logic       PBA_CELL_PROGRAMMED = 1'b1;

endpackage

// ---- pba_rst_sync.sv ----
// Purpose: Release of the active-low reset through two flip-flops
// Assumes: rst_b may assert at any time
// Notes:   Assertion is immediate, release is aligned to mclk
`timescale 1ns/1ns
module pba_rst_sync
  import pba_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_b,
  output logic      rst_sync_b
);

  logic meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg   <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      meta_reg   <= 1'b1;
      rst_sync_b <= meta_reg;
    end
  end

endmodule

// ---- pba_cell_array.sv ----
// Purpose: 64 one-bit nonvolatile cells with a registered sense output
// Assumes: Cells keep their state through reset, like the real array
// Notes:   Erase models the UV exposure and takes priority over programming
`timescale 1ns/1ns
module pba_cell_array
  import pba_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 prog_on,
  input  wire logic [PBA_IDX_W-1:0] cell_index,
  input  wire logic                 erase_all,
  output logic                      sense_out
);

  logic [PBA_CELLS-1:0] cell_state;

  // No reset reaches the cells: they power up unknown until the first
  // erase, so a test environment must hold erase_all high once at start.

  // One cell per entry; programming only ever moves a cell to one
  for (genvar i = 0; i < PBA_CELLS; i++) begin : g_cell
    always_ff @(posedge mclk) begin
      if (erase_all) begin
        cell_state[i] <= PBA_CELL_ERASED;
      end else if (prog_on && (cell_index == PBA_IDX_W'(i))) begin
        cell_state[i] <= PBA_CELL_PROGRAMMED;
      end
    end
  end

  // Sense amplifier, registered and untouched by reset
  always_ff @(posedge mclk) begin
    sense_out <= cell_state[cell_index];
  end

endmodule

// ---- pba_access.sv ----
// Purpose: Register access to the 64-cell personality bit array
// Assumes: Software follows the program and read sequences below
// Notes:   Sensing lags a select write by one cycle
// Contract
// - 64 cells, one addressed by index
// - Index bits 2:0 row, 5:3 column
// - Select bits 7:6 plain storage only
// - Reset clears the whole select register
// - Status bit 7 shows selected cell
// - Sensed bit not reset, never blocks programming
// - Program bit forces selected cell to one
// - Status bit 0 set for row zero
// - Row zero flag reads one after reset
// - Increments walk rows, then next column
// - Select reads back full written byte
// - Erased cell senses as zero
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns
module pba_access
  import pba_pkg::*;
(
  input  wire logic                  mclk,
  input  wire logic                  rst_b,
  input  wire logic [PBA_ADDR_W-1:0] reg_addr,
  input  wire logic [PBA_DATA_W-1:0] reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [PBA_DATA_W-1:0] reg_rdata,
  input  wire logic                  uv_erase,
  output logic                       cell_program_enable,
  output logic                       first_row_flag,
  output logic                       sensed_cell_value,
  output logic      [PBA_IDX_W-1:0]  cell_index
);

  logic                  rst_sync_b;
  logic [PBA_DATA_W-1:0] cell_select_reg;
  logic [PBA_DATA_W-1:0] cell_select_next;
  logic                  prog_enable_reg;
  logic                  first_row_reg;
  logic [PBA_DATA_W-1:0] status_view;
  logic [PBA_DATA_W-1:0] read_mux;
  logic                  sel_hit;
  logic                  scr_hit;
  logic                  sense_bit;

  // Reset release aligned to the clock
  pba_rst_sync u_rst_sync (
    .mclk       (mclk),
    .rst_b      (rst_b),
    .rst_sync_b (rst_sync_b)
  );

  // Address decode; anything else reads as zero and ignores writes
  assign sel_hit = (reg_addr == PBA_SEL_OFS);
  assign scr_hit = (reg_addr == PBA_SCR_OFS);

  // Next select value: the whole byte is kept, spare bits included
  always_comb begin
    cell_select_next = cell_select_reg;
    if (reg_wr && sel_hit) begin
      cell_select_next = reg_wdata;
    end
  end

  // Select register; cleared by reset, which points at row 0 column 0
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cell_select_reg <= PBA_SEL_RESET;
    end else begin
      cell_select_reg <= cell_select_next;
    end
  end

  // Row-zero flag follows the row field of the next select value.
  // Binary layout means an increment from row 7 carries into the column.
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      first_row_reg <= PBA_RZF_RESET;
    end else begin
      first_row_reg <= (cell_select_next[PBA_ROW_LSB +: PBA_ROW_W] == PBA_ROW_ZERO);
    end
  end

  // Program switch; only bit 5 of a status write is taken
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      prog_enable_reg <= PBA_PGM_RESET;
    end else if (reg_wr && scr_hit) begin
      prog_enable_reg <= reg_wdata[PBA_SCR_PGM_BIT];
    end
  end

  // Index is the low six select bits: row in 2:0, column in 5:3
  assign cell_index = cell_select_reg[PBA_IDX_LSB +: PBA_IDX_W];

  // Cell array; the switch acts regardless of the sensed value.
  // Sensing is registered, so a status read strobed right after a
  // select write still shows the previous cell; leave one idle cycle.
  pba_cell_array u_cells (
    .mclk       (mclk),
    .prog_on    (prog_enable_reg),
    .cell_index (cell_index),
    .erase_all  (uv_erase),
    .sense_out  (sense_bit)
  );

  // Status view; unused bits are constant zero
  always_comb begin
    status_view                   = PBA_RD_IDLE;
    status_view[PBA_SCR_DATA_BIT] = sense_bit;
    status_view[PBA_SCR_PGM_BIT]  = prog_enable_reg;
    status_view[PBA_SCR_RZF_BIT]  = first_row_reg;
  end

  // Read mux; unmapped offsets answer zero
  always_comb begin
    read_mux = PBA_RD_IDLE;
    if (sel_hit) begin
      read_mux = cell_select_reg;
    end else if (scr_hit) begin
      read_mux = status_view;
    end
  end

  // Read data stand only in the cycle after the strobe, so stale
  // values never linger on the port for a careless master
  always_ff @(posedge mclk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      reg_rdata <= PBA_RD_IDLE;
    end else if (reg_rd) begin
      reg_rdata <= read_mux;
    end else begin
      reg_rdata <= PBA_RD_IDLE;
    end
  end

  // Direct views for the surrounding analog and test logic
  assign cell_program_enable = prog_enable_reg;
  assign first_row_flag      = first_row_reg;
  assign sensed_cell_value   = sense_bit;

  // ---------------- checks ----------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_sync_b);

  sequence s_sel_write;
    reg_wr && sel_hit;
  endsequence

  sequence s_scr_write;
    reg_wr && scr_hit;
  endsequence

  sequence s_prog_held;
    prog_enable_reg && !uv_erase ##1 $stable(cell_index) && !uv_erase;
  endsequence

  sequence s_sel_read;
    reg_rd && sel_hit;
  endsequence

  sequence s_scr_read;
    reg_rd && scr_hit;
  endsequence

  sequence s_stray_read;
    reg_rd && !sel_hit && !scr_hit;
  endsequence

  sequence s_stray_write;
    reg_wr && !sel_hit && !scr_hit;
  endsequence

  // Two quiet cycles: nothing can move the cell under the sense register
  sequence s_cells_quiet;
    !prog_enable_reg && !uv_erase ##1 !prog_enable_reg && !uv_erase && $stable(cell_index);
  endsequence

  sequence s_erase_held;
    uv_erase ##1 uv_erase;
  endsequence

  chk_sel_after_reset: assert property (
    $rose(rst_sync_b) |-> (cell_select_reg == PBA_SEL_RESET) && !prog_enable_reg && first_row_reg
  ) else $error("select or program state not cleared by reset");

  chk_sel_readback: assert property (
    s_sel_write ##1 (reg_rd && sel_hit && !reg_wr) |=> (reg_rdata == $past(reg_wdata, 2))
  ) else $error("select register did not read back the written byte");

  chk_spare_isolated: assert property (
    s_sel_write |=> (cell_index == $past(reg_wdata[PBA_IDX_W-1:0]))
  ) else $error("cell index does not follow the low select bits");

  chk_row_flag: assert property (
    s_sel_write |=> (first_row_flag == ($past(reg_wdata[PBA_ROW_W-1:0]) == PBA_ROW_ZERO))
  ) else $error("row zero flag wrong after select write");

  chk_pgm_bit: assert property (
    s_scr_write |=> (cell_program_enable == $past(reg_wdata[PBA_SCR_PGM_BIT]))
  ) else $error("program bit did not take the written value");

  chk_prog_sets_cell: assert property (
    s_prog_held |=> sensed_cell_value
  ) else $error("held program did not drive the cell to one");

  chk_status_read: assert property (
    (reg_rd && scr_hit) |=> (reg_rdata[PBA_SCR_DATA_BIT] == $past(sense_bit)) &&
                           (reg_rdata[PBA_SCR_RZF_BIT] == $past(first_row_reg))
  ) else $error("status read does not show sensed bit or row flag");

  chk_unused_zero: assert property (
    (reg_rd && scr_hit) |=> (reg_rdata[6] == 1'b0) && (reg_rdata[4:1] == 4'h0)
  ) else $error("unused status bits read nonzero");

  chk_erase_zero: assert property (
    uv_erase ##1 (!prog_enable_reg && $stable(cell_index)) |=> !sensed_cell_value
  ) else $error("erased cell did not sense zero");

  chk_rdata_idle: assert property (
    !reg_rd |=> (reg_rdata == PBA_RD_IDLE)
  ) else $error("read data present without a read strobe");

  chk_index_walk: assert property (
    s_sel_write ##1 (reg_wr && sel_hit && reg_wdata == $past(reg_wdata) + 8'h01 &&
                    $past(reg_wdata[2:0]) == 3'h7) |=> first_row_flag
  ) else $error("step past row seven did not land on row zero");

  // Register stores change only on a write to their own offset.
  // These run with the synchronised reset, so an asynchronous reset
  // in mid-check simply abandons the attempt.
  chk_spare_kept: assert property (
    s_sel_write |=> (cell_select_reg[PBA_SPARE_HI] == $past(reg_wdata[PBA_SPARE_HI])) &&
                    (cell_select_reg[PBA_SPARE_LO] == $past(reg_wdata[PBA_SPARE_LO]))
  ) else $error("spare select bits did not store the written value");

  chk_sel_held: assert property (
    !(reg_wr && sel_hit) |=> $stable(cell_select_reg)
  ) else $error("select register changed without a select write");

  chk_pgm_held: assert property (
    !(reg_wr && scr_hit) |=> $stable(prog_enable_reg)
  ) else $error("program bit changed without a status write");

  chk_scr_keeps_sel: assert property (
    s_scr_write |=> $stable(cell_select_reg)
  ) else $error("status write disturbed the select register");

  chk_sel_keeps_pgm: assert property (
    s_sel_write |=> $stable(prog_enable_reg)
  ) else $error("select write disturbed the program bit");

  chk_stray_write: assert property (
    s_stray_write |=> $stable(cell_select_reg) && $stable(prog_enable_reg)
  ) else $error("write to an unmapped offset changed a register");

  chk_stray_read: assert property (
    s_stray_read |=> (reg_rdata == PBA_RD_IDLE)
  ) else $error("read of an unmapped offset returned nonzero data");

  chk_sel_read: assert property (
    s_sel_read |=> (reg_rdata == $past(cell_select_reg))
  ) else $error("select read did not return the stored byte");

  chk_status_pgm: assert property (
    s_scr_read |=> (reg_rdata[PBA_SCR_PGM_BIT] == $past(prog_enable_reg))
  ) else $error("status read does not show the program bit");

  // Flag and cell behaviour
  chk_row_matches: assert property (
    first_row_reg == (cell_select_reg[PBA_ROW_LSB +: PBA_ROW_W] == PBA_ROW_ZERO)
  ) else $error("row zero flag disagrees with the selected row");

  chk_flag_after_reset: assert property (
    $rose(rst_sync_b) |-> first_row_flag
  ) else $error("row zero flag not set after reset");

  chk_sense_steady: assert property (
    s_cells_quiet |=> (sensed_cell_value == $past(sensed_cell_value))
  ) else $error("sensed value moved with no select, program or erase");

  chk_erase_held: assert property (
    s_erase_held |=> !sensed_cell_value
  ) else $error("sensed value not zero while erase is held");

endmodule

// ---- pba_access_test.sv ----
// Purpose: Self-checking bench for the personality bit array access block
// Assumes: Cells power up unknown; the bench holds uv_erase high during the first reset
// Notes:   Expected values come from a bench copy of the 64 cells
`timescale 1ns/1ns
module pba_access_test;
  import pba_pkg::*;

  `define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch at %0t: got %h exp %h", $time, got, exp); end end

  logic       mclk, rst_b, reg_wr, reg_rd, uv_erase;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rdv, v, snap;
  logic       cell_program_enable, first_row_flag, sensed_cell_value;
  logic [5:0] cell_index;
  logic       sense_snap;
  logic       model [64];
  int         mismatches, samples_checked;
  int unsigned seed_val;

  pba_access i_dut (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .uv_erase(uv_erase),
    .cell_program_enable(cell_program_enable), .first_row_flag(first_row_flag),
    .sensed_cell_value(sensed_cell_value), .cell_index(cell_index));

  // Free-running 100 MHz clock
  always #5 mclk = ~mclk;

  // Status byte the block should return for a selected cell
  function automatic logic [7:0] exp_scr(input logic [5:0] i, input logic p);
    return {model[i], 1'b0, p, 4'h0, i[2:0] == 3'h0};
  endfunction

  // Write leaves a gap cycle so the strobe is never driven twice in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    @(posedge mclk);
  endtask

  // Read data is taken mid-cycle, where it has settled; port levels are snapped too
  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    @(negedge mclk);
    rdv  = reg_rdata;
    snap = {first_row_flag, cell_program_enable, cell_index};
    sense_snap = sensed_cell_value;
    @(posedge mclk);
  endtask

  // Two writes on consecutive edges, strobe held high between them
  task automatic wr_pair(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1);
    reg_addr  <= a;
    reg_wdata <= d0;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wdata <= d1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    @(posedge mclk);
  endtask

  // Write then read the same offset with no idle cycle between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b1;
    @(posedge mclk);
    reg_rd    <= 1'b0;
    @(negedge mclk);
    rdv = reg_rdata;
    @(posedge mclk);
  endtask

  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask

  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog: the tests need well under 3000 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    mismatches++;
    final_report();
  end

  initial begin
    mclk      = 1'b0;
    rst_b     = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    uv_erase  = 1'b1;
    foreach (model[i]) model[i] = 1'b0;
    seed_val = $urandom(32'h1277);
    @(posedge mclk);
    do_reset();
    uv_erase <= 1'b0;
    rd(PBA_SEL_OFS);
    `CHK(rdv, PBA_SEL_RESET)
    rd(PBA_SCR_OFS);
    `CHK(rdv, 8'h01)
    `CHK(snap, 8'h80)
    `CHK(sense_snap, 1'b0)
    $display("test reset values done");
    // Random selections, cells 08 and 3f first
    for (int k = 0; k < 24; k++) begin
      v = (k == 0) ? 8'h08 : (k == 1) ? 8'h3f : 8'($urandom);
      wr(PBA_SEL_OFS, v);
      rd(PBA_SEL_OFS);
      `CHK(rdv, v)
      `CHK(snap[5:0], v[5:0])
      rd(PBA_SCR_OFS);
      `CHK(rdv, exp_scr(v[5:0], 1'b0))
      `CHK(sense_snap, model[v[5:0]])
    end
    $display("test select done");
    // Programming; cell 08 is programmed twice, the second time already at one
    for (int k = 0; k < 8; k++) begin
      v = (k % 4 == 0) ? 8'h08 : (k == 1) ? 8'h3f : (k == 2) ? 8'h00 : 8'($urandom);
      wr(PBA_SEL_OFS, v);
      wr(PBA_SCR_OFS, 8'hff);
      repeat (3) @(posedge mclk);
      model[v[5:0]] = 1'b1;
      rd(PBA_SCR_OFS);
      `CHK(rdv, exp_scr(v[5:0], 1'b1))
      `CHK(snap[6], 1'b1)
      `CHK(sense_snap, 1'b1)
      wr(PBA_SCR_OFS, 8'h00);
    end
    $display("test program done");
    // Increment walk by read-modify-write across two columns
    wr(PBA_SEL_OFS, 8'hc0);
    for (int k = 0; k < 16; k++) begin
      rd(PBA_SEL_OFS);
      v = rdv + 8'h01;
      wr(PBA_SEL_OFS, v);
      rd(PBA_SCR_OFS);
      `CHK(rdv, exp_scr(v[5:0], 1'b0))
      `CHK(snap[7], v[2:0] == 3'h0)
    end
    $display("test increment done");
    // Unmapped offset must neither store nor disturb the select register
    wr(8'h30, 8'h5a);
    rd(8'h30);
    `CHK(rdv, 8'h00)
    rd(PBA_SEL_OFS);
    `CHK(rdv, 8'hd0)
    $display("test unmapped done");
    // Back-to-back strobes: a step from row seven, then a write read straight back
    wr_pair(PBA_SEL_OFS, 8'h07, 8'h08);
    rd(PBA_SCR_OFS);
    `CHK(rdv, exp_scr(6'h08, 1'b0))
    `CHK(snap[7], 1'b1)
    wr_rd(PBA_SEL_OFS, 8'ha7);
    `CHK(rdv, 8'ha7)
    $display("test back-to-back done");
    // Erase returns every cell to zero
    uv_erase <= 1'b1;
    repeat (2) @(posedge mclk);
    uv_erase <= 1'b0;
    foreach (model[i]) model[i] = 1'b0;
    wr(PBA_SEL_OFS, 8'h08);
    rd(PBA_SCR_OFS);
    `CHK(rdv, exp_scr(6'h08, 1'b0))
    $display("test erase done");
    // Reset in mid-programming: select and program bit clear, cells survive
    wr(PBA_SEL_OFS, 8'hc5);
    wr(PBA_SCR_OFS, 8'h20);
    repeat (3) @(posedge mclk);
    do_reset();
    rd(PBA_SEL_OFS);
    `CHK(rdv, 8'h00)
    `CHK(snap, 8'h80)
    wr(PBA_SEL_OFS, 8'h05);
    rd(PBA_SCR_OFS);
    `CHK(rdv, 8'h80)
    `CHK(sense_snap, 1'b1)
    $display("test mid-run reset done");
    final_report();
  end
endmodule
